//--- verilog/rca_top.sv
// Coexistence signalling: periodic request, hold-off, directional priority, receive-active
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/1ps
module rca_top #(
  parameter bit PWM_AT_STARTUP = 1'b1
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic radio_req_i,
  input wire logic radio_tx_i,
  input wire logic grant_i,
  input wire logic hold_pin_i,
  input wire logic frame_detect_i,
  output logic req_o,
  output logic pwm_req_o,
  output logic pwm_req_oe_o,
  output logic pri_o,
  output logic pri_oe_o,
  output logic dir_pri_o,
  output logic dir_pri_oe_o,
  output logic rx_active_o,
  output logic rx_active_oe_o,
  output logic tx_allowed_o,
  output logic ack_allow_o
);
  localparam logic [11:0] CTRL_INIT =
    rca_pkg::CTRL_RST | (12'(PWM_AT_STARTUP) << rca_pkg::B_PWM_EN);

  rca_tmr_if tmr ();

  // Register file
  logic [11:0] ctrl;
  logic [7:0] per_code;
  logic [6:0] duty_code;
  logic [7:0] dpw;
  logic [31:0] rdata;
  logic [11:0] next_ctrl;
  logic [7:0] next_per_code;
  logic [6:0] next_duty_code;
  logic [7:0] next_dpw;
  logic [31:0] next_rdata;
  logic [4:0] status;

  always_comb begin
    next_ctrl = ctrl;
    next_per_code = per_code;
    next_duty_code = duty_code;
    next_dpw = dpw;
    next_rdata = 32'h0000_0000;
    if (wr_i) begin
      if (addr_i == rca_pkg::OFF_CTRL) begin
        next_ctrl = wdata_i[11:0];
      end else if (addr_i == rca_pkg::OFF_PWM) begin
        next_per_code = wdata_i[7:0];
        next_duty_code = wdata_i[14:8];
      end else if (addr_i == rca_pkg::OFF_DPW) begin
        next_dpw = wdata_i[7:0];
      end
    end
    if (rd_i) begin
      if (addr_i == rca_pkg::OFF_CTRL) begin
        next_rdata = {20'h00000, ctrl};
      end else if (addr_i == rca_pkg::OFF_PWM) begin
        next_rdata = {17'h00000, duty_code, per_code};
      end else if (addr_i == rca_pkg::OFF_DPW) begin
        next_rdata = {24'h000000, dpw};
      end else if (addr_i == rca_pkg::OFF_STAT) begin
        next_rdata = {27'h0000000, status};
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl <= CTRL_INIT; // see R1
      per_code <= rca_pkg::PER_RST;
      duty_code <= rca_pkg::DUTY_RST;
      dpw <= rca_pkg::DPW_RST; // see R12
      rdata <= 32'h0000_0000;
    end else begin
      ctrl <= next_ctrl;
      per_code <= next_per_code;
      duty_code <= next_duty_code;
      dpw <= next_dpw;
      rdata <= next_rdata;
    end
  end
  assign rdata_o = rdata;

  // Configuration decode; out-of-range codes are clamped rather than rejected
  logic [7:0] per_used;
  logic [6:0] duty_used;
  logic hold_off;
  logic dp_on;
  logic [16:0] period_us;
  logic [16:0] on_us;

  always_comb begin
    per_used = per_code;
    if (per_code < rca_pkg::PER_MIN) begin
      per_used = rca_pkg::PER_MIN; // see R2
    end else if (per_code > rca_pkg::PER_MAX) begin
      per_used = rca_pkg::PER_MAX;
    end
    duty_used = duty_code;
    if (duty_code < rca_pkg::DUTY_MIN) begin
      duty_used = rca_pkg::DUTY_MIN; // see R4
    end else if (duty_code > rca_pkg::DUTY_MAX) begin
      duty_used = rca_pkg::DUTY_MAX;
    end
  end

  assign period_us = 17'(per_used) * 17'(rca_pkg::HALF_MS_US);
  // Exact in microseconds, so no rounding is lost to the tick
  assign on_us = 17'(per_used) * 17'(duty_used) * 17'(rca_pkg::PWM_ON_SCALE); // see R20
  assign hold_off = ctrl[rca_pkg::B_HOLD_EN] &
                    ~(hold_pin_i ^ ctrl[rca_pkg::B_HOLD_HI]); // see R6 R7
  assign dp_on = ctrl[rca_pkg::B_DP_EN] & (dpw != 8'h00); // see R13

  // Core state
  logic [6:0] tick_cnt;
  logic [16:0] us_cnt;
  logic pwm_gate;
  logic pwm_act;
  logic req_active;
  logic comb_req_q;
  rca_pkg::rca_dp_e dp_state;
  logic [6:0] next_tick_cnt;
  logic [16:0] next_us_cnt;
  logic next_pwm_gate;
  logic next_pwm_act;
  logic next_req_active;
  rca_pkg::rca_dp_e next_dp_state;
  logic tick;
  logic comb_req;
  logic static_pri;

  assign tick = (tick_cnt == rca_pkg::TICK_LAST);
  assign comb_req = req_active | pwm_act; // see R17
  // Periodic phase alone uses its own priority choice
  assign static_pri = (pwm_act & ~req_active) ? ctrl[rca_pkg::B_PWM_PRI] :
                      (radio_tx_i ? ctrl[rca_pkg::B_TX_HI] : ctrl[rca_pkg::B_RX_HI]); // see R5 R10

  always_comb begin
    next_tick_cnt = tick ? 7'h00 : tick_cnt + 7'h01;
    next_us_cnt = us_cnt;
    next_pwm_gate = pwm_gate;
    if (!ctrl[rca_pkg::B_PWM_EN]) begin
      next_us_cnt = 17'h00000; // see R1
    end else if (tick) begin
      next_us_cnt = (us_cnt >= period_us - 17'h00001) ? 17'h00000 : us_cnt + 17'h00001;
    end
    if (us_cnt == 17'h00000) begin
      next_pwm_gate = ~hold_off; // see R21
    end
    next_pwm_act = ctrl[rca_pkg::B_PWM_EN] & pwm_gate & (us_cnt < on_us); // see R4 R20
    // A request already held survives hold-off; only a fresh one is refused
    next_req_active = radio_req_i & (req_active | ~hold_off); // see R21
    next_dp_state = dp_state;
    case (dp_state)
      rca_pkg::RCA_DP_IDLE: begin
        if (dp_on && comb_req && !comb_req_q) begin
          next_dp_state = rca_pkg::RCA_DP_PULSE; // see R8
        end
      end
      rca_pkg::RCA_DP_PULSE: begin
        if (!tmr.busy) begin
          next_dp_state = rca_pkg::RCA_DP_RADIO;
        end
      end
      rca_pkg::RCA_DP_RADIO: begin
        if (!comb_req) begin
          next_dp_state = rca_pkg::RCA_DP_IDLE;
        end
      end
      default: begin
        next_dp_state = rca_pkg::RCA_DP_IDLE;
      end
    endcase
    if (!dp_on || !comb_req) begin
      next_dp_state = rca_pkg::RCA_DP_IDLE; // see R13
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tick_cnt <= 7'h00;
      us_cnt <= 17'h00000;
      pwm_gate <= 1'b0;
      pwm_act <= 1'b0;
      req_active <= 1'b0;
      comb_req_q <= 1'b0;
      dp_state <= rca_pkg::RCA_DP_IDLE;
    end else begin
      tick_cnt <= next_tick_cnt;
      us_cnt <= next_us_cnt;
      pwm_gate <= next_pwm_gate;
      pwm_act <= next_pwm_act;
      req_active <= next_req_active;
      comb_req_q <= comb_req;
      dp_state <= next_dp_state;
    end
  end

  // Timer channel zero is launched by the rising edge of the combined request comb_req, including a periodic phase
  assign tmr.start = dp_on & comb_req & ~comb_req_q & (dp_state == rca_pkg::RCA_DP_IDLE); // see R14
  assign tmr.width = dpw;
  assign tmr.tick = tick;
  rca_pulse_timer u_timer (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .tmr(tmr)
  );

  assign status = {grant_i, dp_state == rca_pkg::RCA_DP_PULSE, pwm_act, req_active, hold_off};

  // Pin outputs
  logic next_req;
  logic next_pwm_req;
  logic next_pri;
  logic next_dir_pri;
  logic next_rx_active;
  logic next_tx_allowed;
  logic next_ack_allow;

  always_comb begin
    next_req = ctrl[rca_pkg::B_SHARED] ? req_active : comb_req; // see R17
    next_pwm_req = ctrl[rca_pkg::B_SHARED] & comb_req; // see R17
    // Deasserted level follows polarity; assert level active high needed in directional mode
    next_pri = ~(comb_req & static_pri) ^ ctrl[rca_pkg::B_PRI_HI]; // see R11 R18
    next_dir_pri = 1'b0;
    // Bypass drops the line at once, even in the middle of a transfer
    if (dp_on && dp_state == rca_pkg::RCA_DP_PULSE) begin
      next_dir_pri = static_pri; // see R8 R10
    end else if (dp_on && dp_state == rca_pkg::RCA_DP_RADIO) begin
      next_dir_pri = radio_tx_i; // see R9
    end
    next_rx_active = ctrl[rca_pkg::B_RXA_EN] &
                     ~(frame_detect_i ^ ctrl[rca_pkg::B_RXA_HI]); // see R15 R16
    next_tx_allowed = ~hold_off; // see R21
    next_ack_allow = ~(ctrl[rca_pkg::B_ACK_DIS] & (hold_off | ~grant_i)); // see R19
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      req_o <= 1'b0;
      pwm_req_o <= 1'b0;
      pwm_req_oe_o <= 1'b0;
      pri_o <= 1'b0;
      pri_oe_o <= 1'b0;
      dir_pri_o <= 1'b0;
      dir_pri_oe_o <= 1'b0;
      rx_active_o <= 1'b0;
      rx_active_oe_o <= 1'b0;
      tx_allowed_o <= 1'b0;
      ack_allow_o <= 1'b0;
    end else begin
      req_o <= next_req;
      pwm_req_o <= next_pwm_req;
      pwm_req_oe_o <= ctrl[rca_pkg::B_SHARED];
      pri_o <= next_pri;
      pri_oe_o <= ~dp_on; // see R10
      dir_pri_o <= next_dir_pri;
      dir_pri_oe_o <= dp_on;
      rx_active_o <= next_rx_active;
      rx_active_oe_o <= ctrl[rca_pkg::B_RXA_EN]; // see R15
      tx_allowed_o <= next_tx_allowed;
      ack_allow_o <= next_ack_allow;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  a_pwm_stays_off: assert property (!ctrl[rca_pkg::B_PWM_EN] |=> !pwm_act) // see R1
    else $error("periodic request while disabled");
  a_period_clamped: assert property ( // see R2
    per_used >= rca_pkg::PER_MIN && per_used <= rca_pkg::PER_MAX)
    else $error("period code out of range");
  a_duty_clamped: assert property ( // see R4
    duty_used >= rca_pkg::DUTY_MIN && duty_used <= rca_pkg::DUTY_MAX)
    else $error("duty code out of range");
  a_hold_ignored: assert property (!ctrl[rca_pkg::B_HOLD_EN] |-> !hold_off) // see R6
    else $error("hold-off seen while disabled");
  a_hold_polarity: assert property ( // see R7
    ctrl[rca_pkg::B_HOLD_EN] |-> hold_off == (hold_pin_i == ctrl[rca_pkg::B_HOLD_HI]))
    else $error("hold-off polarity wrong");
  a_pulse_first: assert property ( // see R8
    dp_on && comb_req && !comb_req_q |=>
    dp_state == rca_pkg::RCA_DP_PULSE ##1 dir_pri_o == $past(static_pri && dp_on))
    else $error("directional pulse missing");
  a_radio_level: assert property ( // see R9
    dp_on && dp_state == rca_pkg::RCA_DP_RADIO && comb_req |=> dir_pri_o == $past(radio_tx_i))
    else $error("radio state level wrong");
  a_static_undriven: assert property (dp_on |=> !pri_oe_o) // see R10
    else $error("static priority driven in directional mode");
  a_static_idle: assert property ( // see R11
    !comb_req |=> pri_o == !$past(ctrl[rca_pkg::B_PRI_HI]))
    else $error("priority asserted without request");
  a_bypass_idle: assert property ( // see R13
    !dp_on |=> dp_state == rca_pkg::RCA_DP_IDLE && !dir_pri_o)
    else $error("directional logic active with zero width");
  a_rxa_off: assert property ( // see R15
    !ctrl[rca_pkg::B_RXA_EN] |=> !rx_active_oe_o && !rx_active_o)
    else $error("receive-active drives while disabled");
  a_rxa_level: assert property ( // see R16
    ctrl[rca_pkg::B_RXA_EN] && frame_detect_i |=> rx_active_o == $past(ctrl[rca_pkg::B_RXA_HI]))
    else $error("receive-active level wrong");
  a_shared_or: assert property ( // see R17
    ctrl[rca_pkg::B_SHARED] && comb_req |=> pwm_req_o)
    else $error("shared request pin not combined");
  a_ack_blocked: assert property ( // see R19
    ctrl[rca_pkg::B_ACK_DIS] && (hold_off || !grant_i) |=> !ack_allow_o)
    else $error("ack allowed during hold-off");
  a_no_new_req: assert property ( // see R21
    hold_off && !req_active |=> !req_active [*1] ##1 !req_o || !ctrl[rca_pkg::B_SHARED])
    else $error("request started during hold-off");
  c_pwm_phase: cover property (pwm_act ##1 !pwm_act);
  c_dp_sequence: cover property (dp_state == rca_pkg::RCA_DP_PULSE ##1 dp_state == rca_pkg::RCA_DP_RADIO);
  c_hold_refuse: cover property (hold_off && radio_req_i && !req_active);
endmodule

//--- verilog/rca_pkg.sv
// Constants, register map and types of the radio coexistence signalling block
// Behaviour
// R1: Startup option set starts periodic requests at once; otherwise software enables them.
// R2: Period code spans 10 to 218 half-milliseconds, 5 ms to 109 ms.
// R3: Configurer avoids periods dividing the beacon interval evenly.
// R4: Duty cycle spans 1 to 95 percent in one-percent steps.
// R5: A bit chooses whether priority asserts during each periodic request phase.
// R6: Hold-off disabled means pin ignored and hold-off always deasserted.
// R7: A polarity bit chooses whether high or low pin means hold-off.
// R8: Directional mode sends a priority pulse, then reports radio state on that line.
// R9: In radio-state phase the line is low for receive, high for transmit.
// R10: Directional mode keeps static priority off its pin, used only internally.
// R11: Without directional mode priority pin is a static level during request.
// R12: Pulse hold time is 1 to 255 microseconds, reset value 20.
// R13: Pulse width zero bypasses directional priority entirely.
// R14: Directional output comes from timer channel zero tied to the request pin.
// R15: Receive-active enabled routes frame detection out; disabled uses no pin.
// R16: Receive-active polarity picks the level shown while a packet is detected.
// R17: Shared request drives request OR periodic request on a second pin.
// R18: Configurer sets priority active high when directional mode is used.
// R19: Acknowledge-disable suppresses acks while hold-off asserted or grant deasserted.
// R20: Asserted time per period is period times duty divided by one hundred.
// R21: During hold-off no new transmission and no new request begins.
package rca_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned US_NS = 1000;
  localparam int unsigned TICK_CYCLES = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [6:0] TICK_LAST = 7'(TICK_CYCLES - 1);
  localparam int unsigned HALF_MS_US = 500;
  localparam int unsigned PWM_ON_SCALE = HALF_MS_US / 100;
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_PWM = 4'h4;
  localparam logic [3:0] OFF_DPW = 4'h8;
  localparam logic [3:0] OFF_STAT = 4'hC;
  localparam int CTRL_W = 12;
  localparam int B_PWM_EN = 0;
  localparam int B_PWM_PRI = 1;
  localparam int B_HOLD_EN = 2;
  localparam int B_HOLD_HI = 3;
  localparam int B_DP_EN = 4;
  localparam int B_PRI_HI = 5;
  localparam int B_TX_HI = 6;
  localparam int B_RX_HI = 7;
  localparam int B_RXA_EN = 8;
  localparam int B_RXA_HI = 9;
  localparam int B_SHARED = 10;
  localparam int B_ACK_DIS = 11;
  localparam int PWM_DUTY_LSB = 8;
  localparam logic [11:0] CTRL_RST = 12'h020;
  localparam logic [7:0] PER_MIN = 8'h0A;
  localparam logic [7:0] PER_MAX = 8'hDA;
  localparam logic [7:0] PER_RST = 8'h4E;
  localparam logic [6:0] DUTY_MIN = 7'h01;
  localparam logic [6:0] DUTY_MAX = 7'h5F;
  localparam logic [6:0] DUTY_RST = 7'h14;
  localparam logic [7:0] DPW_RST = 8'h14;
  typedef enum logic [2:0] {
    RCA_DP_IDLE = 3'b001,
    RCA_DP_PULSE = 3'b010,
    RCA_DP_RADIO = 3'b100
  } rca_dp_e;
endpackage

//--- verilog/rca_tmr_if.sv
// Link between the directional sequencer and the pulse timer channel
`timescale 1ns/1ps
interface rca_tmr_if;
  logic start;
  logic [7:0] width;
  logic tick;
  logic busy;
  modport ctrl (output start, output width, output tick, input busy);
  modport timer (input start, input width, input tick, output busy);
endinterface

//--- verilog/rca_pulse_timer.sv
// Timer compare channel zero: times the directional priority pulse in microseconds
`timescale 1ns/1ps
module rca_pulse_timer (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  rca_tmr_if.timer tmr
);
  logic [7:0] cnt;
  logic [7:0] next_cnt;

  always_comb begin
    next_cnt = cnt;
    if (tmr.start) begin
      next_cnt = tmr.width; // see R12
    end else if (tmr.tick && cnt != 8'h00) begin
      next_cnt = cnt - 8'h01;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt <= 8'h00;
    end else begin
      cnt <= next_cnt;
    end
  end

  // Busy covers the whole pulse; the first microsecond may be short by under one tick
  assign tmr.busy = (cnt != 8'h00);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  a_timer_loads: assert property (tmr.start && tmr.width != 8'h00 |=> tmr.busy) // see R12
    else $error("pulse timer did not start");
  a_timer_zero: assert property (tmr.start |-> tmr.width != 8'h00) // see R13
    else $error("zero width pulse launched");
endmodule

//--- testbench/rca_arbiter_model.sv
// Behavioural traffic arbiter answering the request pin with a grant
`timescale 1ns/1ps
module rca_arbiter_model (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic req_i,
  input wire logic deny_i,
  input wire logic slow_i,
  output logic grant_o
);
  logic [2:0] wait_cnt;
  // Slow mode grants four cycles late, as a busy arbiter would
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wait_cnt <= 3'h0;
      grant_o <= 1'b0;
    end else begin
      wait_cnt <= !req_i ? 3'h0 : (wait_cnt == 3'h7) ? wait_cnt : wait_cnt + 3'h1;
      grant_o <= req_i && !deny_i && (wait_cnt >= (slow_i ? 3'h4 : 3'h0));
    end
  end
endmodule

//--- testbench/tb_rca_top.sv
// Self-checking bench for the radio coexistence signalling block
`timescale 1ns/1ps
module tb_rca_top;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [3:0] addr_i = 4'h0;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic radio_req_i = 1'b0;
  logic radio_tx_i = 1'b0;
  logic hold_pin_i = 1'b0;
  logic frame_detect_i = 1'b0;
  logic deny = 1'b0;
  logic slow = 1'b0;
  logic grant_i;
  logic [31:0] rdata_o;
  logic req_o, pwm_req_o, pwm_req_oe_o, pri_o, pri_oe_o, dir_pri_o, dir_pri_oe_o;
  logic rx_active_o, rx_active_oe_o, tx_allowed_o, ack_allow_o;
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;
  integer seed = 24084;
  int n;
  int w;
  logic [31:0] r;
  always #5 clk_i = ~clk_i;
  rca_top #(.PWM_AT_STARTUP(1'b1)) DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .radio_req_i(radio_req_i),
    .radio_tx_i(radio_tx_i), .grant_i(grant_i), .hold_pin_i(hold_pin_i),
    .frame_detect_i(frame_detect_i), .req_o(req_o), .pwm_req_o(pwm_req_o),
    .pwm_req_oe_o(pwm_req_oe_o), .pri_o(pri_o), .pri_oe_o(pri_oe_o), .dir_pri_o(dir_pri_o),
    .dir_pri_oe_o(dir_pri_oe_o), .rx_active_o(rx_active_o), .rx_active_oe_o(rx_active_oe_o),
    .tx_allowed_o(tx_allowed_o), .ack_allow_o(ack_allow_o));
  rca_arbiter_model arb (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_i(req_o), .deny_i(deny),
    .slow_i(slow), .grant_o(grant_i));
  function automatic logic [31:0] bv(input int b);
    return 32'h1 << b;
  endfunction
  // Asserted cycles per period: clamped code times clamped duty times 5 us
  function automatic int on_cycles(input int code, input int duty);
    int c;
    int d;
    c = code < 10 ? 10 : code > 218 ? 218 : code;
    d = duty < 1 ? 1 : duty > 95 ? 95 : duty;
    return c * d * 5 * 100;
  endfunction
  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask
  // Shared request: periodic phase shows on the second pin only, priority as chosen
  task automatic pwm_run(input int code, input int duty, input bit p);
    wr(rca_pkg::OFF_PWM, 32'(code) | (32'(duty) << rca_pkg::PWM_DUTY_LSB));
    wr(rca_pkg::OFF_CTRL, bv(0) | (p ? bv(1) : 0) | bv(5) | bv(10));
    n = 0;
    while (pwm_req_o !== 1'b1 && n < 1000) begin
      step(1);
      n++;
    end
    n = 0;
    while (pwm_req_o === 1'b1 && n < 20000) begin
      step(1);
      n++;
      if (n == 200) begin
        check(req_o, 32'h0);
        check(pwm_req_oe_o, 32'h1);
        check(pri_o, 32'(p));
      end
    end
    w = on_cycles(code, duty);
    check(32'(n >= w - 101 && n <= w + 101), 1);
    wr(rca_pkg::OFF_CTRL, bv(5));
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      miscompares++;
      wrap_up();
    end
  end
  initial begin
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    step(10);
    check(req_o, 32'h1);
    rd(rca_pkg::OFF_CTRL, r);
    check(r, 32'(rca_pkg::CTRL_RST) | 32'h1);
    rd(rca_pkg::OFF_PWM, r);
    check(r, {17'h0, rca_pkg::DUTY_RST, rca_pkg::PER_RST});
    rd(rca_pkg::OFF_DPW, r);
    check(r, {24'h0, rca_pkg::DPW_RST});
    rd(4'h2, r);
    check(r, 32'h0);
    wr(rca_pkg::OFF_CTRL, bv(5));
    step(10);
    check(req_o, 32'h0);
    pwm_run(10, 1, 1'b1);
    pwm_run(5, 3, 1'b0);
    // Hold-off enable and polarity, random pin levels
    repeat (8) begin
      w = $random(seed) & 7;
      wr(rca_pkg::OFF_CTRL, bv(5) | (w[0] ? bv(2) : 0) | (w[1] ? bv(3) : 0));
      hold_pin_i <= w[2];
      step(3);
      check(tx_allowed_o, 32'(!(w[0] && (w[2] == w[1]))));
    end
    wr(rca_pkg::OFF_CTRL, bv(5) | bv(2) | bv(3));
    hold_pin_i <= 1'b1;
    radio_req_i <= 1'b1;
    step(6);
    check(req_o, 32'h0);
    check(tx_allowed_o, 32'h0);
    rd(rca_pkg::OFF_STAT, r);
    check(r, 32'h1);
    hold_pin_i <= 1'b0;
    radio_req_i <= 1'b0;
    step(3);
    // Acknowledge suppression against grant and hold-off
    wr(rca_pkg::OFF_CTRL, bv(5) | bv(2) | bv(3) | bv(11));
    radio_req_i <= 1'b1;
    slow <= 1'b1;
    step(12);
    check(ack_allow_o, 32'h1);
    deny <= 1'b1;
    step(4);
    check(ack_allow_o, 32'h0);
    deny <= 1'b0;
    hold_pin_i <= 1'b1;
    step(4);
    check(ack_allow_o, 32'h0);
    wr(rca_pkg::OFF_CTRL, bv(5) | bv(2) | bv(3));
    step(3);
    check(ack_allow_o, 32'h1);
    hold_pin_i <= 1'b0;
    radio_req_i <= 1'b0;
    // Static priority, both assert levels
    for (int h = 0; h < 2; h++) begin
      wr(rca_pkg::OFF_CTRL, (h ? bv(5) : 0) | bv(6));
      radio_tx_i <= 1'b1;
      radio_req_i <= 1'b1;
      step(4);
      check(pri_o, 32'(h));
      check(pri_oe_o, 32'h1);
      check(dir_pri_oe_o, 32'h0);
      radio_tx_i <= 1'b0;
      step(4);
      check(pri_o, 32'(!h));
      radio_req_i <= 1'b0;
      step(4);
    end
    // Directional priority: pulse of random width, then radio state
    w = 1 + (($random(seed) & 32'h7FFF) % 6);
    wr(rca_pkg::OFF_DPW, 32'(w));
    wr(rca_pkg::OFF_CTRL, bv(4) | bv(5) | bv(7));
    radio_tx_i <= 1'b0;
    radio_req_i <= 1'b1;
    n = 0;
    while (dir_pri_o !== 1'b1 && n < 10) begin
      step(1);
      n++;
    end
    check(pri_oe_o, 32'h0);
    check(dir_pri_oe_o, 32'h1);
    n = 0;
    while (dir_pri_o === 1'b1 && n < 1000) begin
      step(1);
      n++;
    end
    check(32'(n >= w * 100 - 101 && n <= w * 100 + 2), 1);
    radio_tx_i <= 1'b1;
    step(4);
    check(dir_pri_o, 32'h1);
    radio_tx_i <= 1'b0;
    step(4);
    check(dir_pri_o, 32'h0);
    radio_req_i <= 1'b0;
    wr(rca_pkg::OFF_DPW, 32'h0);
    step(3);
    check(pri_oe_o, 32'h1);
    check(dir_pri_oe_o, 32'h0);
    wr(rca_pkg::OFF_DPW, 32'hFF);
    wr(rca_pkg::OFF_STAT, 32'hFF);
    rd(rca_pkg::OFF_DPW, r);
    check(r, 32'hFF);
    // Receive-active enable and polarity
    for (int k = 0; k < 8; k++) begin
      wr(rca_pkg::OFF_CTRL, (k[0] ? bv(8) : 0) | (k[1] ? bv(9) : 0));
      frame_detect_i <= k[2];
      step(3);
      check(rx_active_oe_o, 32'(k[0]));
      if (k[0]) begin
        check(rx_active_o, 32'(k[2] == k[1]));
      end
    end
    wrap_up();
  end
endmodule
